// ---- hw/burst_sram_pkg.sv ----
// shared constants and carriers for the pipelined burst sram
package burst_sram_pkg;

    // 1: 36-bit wide organisation, 0: 18-bit organisation
    localparam bit WIDE_CFG = 1'b1;

    localparam int LANE_W = 9;
    localparam int LANES = WIDE_CFG ? 4 : 2;
    localparam int DATA_W = LANES * LANE_W;
    localparam int ADDR_W = WIDE_CFG ? 19 : 20;
    localparam int DEPTH = 2 ** ADDR_W;
    localparam int BURST_W = 2;
    localparam int LANE_PINS = 4;

    localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

    // one access travelling down the pipeline
    typedef struct packed {
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] lane_sel_n;
    } access_t;

    // burst bookkeeping kept between load and advance cycles
    typedef struct packed {
        logic active;
        logic write;
        logic [ADDR_W-1:0] base;
        logic [BURST_W-1:0] count;
    } burst_t;

    localparam access_t ACCESS_IDLE = '0;
    localparam burst_t BURST_IDLE = '0;

endpackage : burst_sram_pkg

// ---- hw/burst_sram_array.sv ----
// storage array with per-lane writes and registered read data
`timescale 1ns/10ps
module burst_sram_array (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic en,
    input wire logic rd_en,
    input wire logic [burst_sram_pkg::ADDR_W-1:0] rd_addr,
    input wire logic wr_en,
    input wire logic [burst_sram_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [burst_sram_pkg::LANES-1:0] wr_lane_n,
    input wire logic [burst_sram_pkg::DATA_W-1:0] wr_data,
    output logic [burst_sram_pkg::DATA_W-1:0] rd_data
);

    logic [burst_sram_pkg::DATA_W-1:0] cells [0:burst_sram_pkg::DEPTH-1];
    logic [burst_sram_pkg::DATA_W-1:0] merged;

    wire same_word = wr_en && (wr_addr == rd_addr);

    // a read meeting a write to the same word sees the new bytes
    always_comb begin
        merged = cells[rd_addr];
        for (int l = 0; l < burst_sram_pkg::LANES; l++) begin
            if (same_word && !wr_lane_n[l]) begin
                merged[l*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W] =
                    wr_data[l*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (en && wr_en) begin
            for (int l = 0; l < burst_sram_pkg::LANES; l++) begin
                if (!wr_lane_n[l]) begin
                    cells[wr_addr][l*burst_sram_pkg::LANE_W +:
                        burst_sram_pkg::LANE_W] <=
                        wr_data[l*burst_sram_pkg::LANE_W +:
                        burst_sram_pkg::LANE_W];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (en && rd_en) begin
            rd_data <= merged;
        end
    end

endmodule : burst_sram_array

// ---- hw/pipelined_sync_burst_sram.sv ----
// pipelined burst sram: input capture, burst counter, data pipeline
`timescale 1ns/10ps
module pipelined_sync_burst_sram (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [burst_sram_pkg::ADDR_W-1:0] addr,
    input wire logic chip_select_1_n,
    input wire logic chip_select_2,
    input wire logic chip_select_3_n,
    input wire logic advance_or_load,
    input wire logic clock_enable_n,
    input wire logic write_enable_n,
    input wire logic byte_write_sel_lane0_n,
    input wire logic byte_write_sel_lane1_n,
    input wire logic byte_write_sel_lane2_n,
    input wire logic byte_write_sel_lane3_n,
    input wire logic burst_order_interleaved,
    input wire logic output_enable_n,
    input wire logic [burst_sram_pkg::DATA_W-1:0] data_in,
    output logic [burst_sram_pkg::DATA_W-1:0] data_out,
    output logic data_oe
);

    // reset release through two flops
    logic rst_meta_reg;
    logic rst_n_reg;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // asynchronous burst-order pin synchronised before use
    logic mode_meta_reg;
    logic mode_reg;

    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            mode_meta_reg <= 1'b0;
            mode_reg <= 1'b0;
        end else begin
            mode_meta_reg <= burst_order_interleaved;
            mode_reg <= mode_meta_reg;
        end
    end

    // pipeline and burst state
    burst_sram_pkg::access_t s1_reg;
    burst_sram_pkg::access_t s1_next;
    burst_sram_pkg::access_t s2_reg;
    burst_sram_pkg::burst_t burst_reg;
    burst_sram_pkg::burst_t burst_next;
    logic drive_reg;

    // decode of the pins in the current cycle
    wire en = !clock_enable_n;
    wire selected = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
    wire load = !advance_or_load;
    wire advance_ok = advance_or_load && burst_reg.active;
    wire [burst_sram_pkg::LANE_PINS-1:0] lane_pins_n = {
        byte_write_sel_lane3_n, byte_write_sel_lane2_n,
        byte_write_sel_lane1_n, byte_write_sel_lane0_n};
    // upper selects exist only in the wide organisation
    wire [burst_sram_pkg::LANES-1:0] lane_sel_n =
        lane_pins_n[burst_sram_pkg::LANES-1:0];
    wire [burst_sram_pkg::BURST_W-1:0] count_step =
        burst_reg.count + burst_sram_pkg::BURST_STEP;
    wire [burst_sram_pkg::BURST_W-1:0] burst_start =
        burst_reg.base[burst_sram_pkg::BURST_W-1:0];
    wire [burst_sram_pkg::BURST_W-1:0] low_linear =
        burst_start + count_step;
    wire [burst_sram_pkg::BURST_W-1:0] low_interleaved =
        burst_start ^ count_step;
    wire [burst_sram_pkg::BURST_W-1:0] burst_low =
        mode_reg ? low_interleaved : low_linear;
    wire [burst_sram_pkg::ADDR_W-1:0] burst_addr =
        {burst_reg.base[burst_sram_pkg::ADDR_W-1:burst_sram_pkg::BURST_W],
        burst_low};

    // next access entering the pipeline
    always_comb begin
        s1_next = burst_sram_pkg::ACCESS_IDLE;
        burst_next = burst_reg;
        if (load) begin
            if (selected) begin
                s1_next.valid = 1'b1;
                s1_next.write = !write_enable_n;
                s1_next.addr = addr;
                s1_next.lane_sel_n = lane_sel_n;
                burst_next.active = 1'b1;
                burst_next.write = !write_enable_n;
                burst_next.base = addr;
                burst_next.count = burst_sram_pkg::BURST_FIRST;
            end else begin
                burst_next.active = 1'b0;
            end
        end else if (advance_ok) begin
            s1_next.valid = 1'b1;
            s1_next.write = burst_reg.write;
            s1_next.addr = burst_addr;
            s1_next.lane_sel_n = lane_sel_n;
            burst_next.count = count_step;
        end
    end

    // capture stage; the clock enable freezes everything
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            s1_reg <= burst_sram_pkg::ACCESS_IDLE;
            burst_reg <= burst_sram_pkg::BURST_IDLE;
        end else if (en) begin
            s1_reg <= s1_next;
            burst_reg <= burst_next;
        end
    end

    // second stage carries pending accesses regardless of selection
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            s2_reg <= burst_sram_pkg::ACCESS_IDLE;
            drive_reg <= 1'b0;
        end else if (en) begin
            s2_reg <= s1_reg;
            drive_reg <= s1_reg.valid && !s1_reg.write;
        end
    end

    wire rd_en = s1_reg.valid && !s1_reg.write;
    wire wr_en = s2_reg.valid && s2_reg.write;

    // reads launch one edge after capture, writes take data two after
    burst_sram_array u_array (
        .clk_sys(clk_sys),
        .rst_n(rst_n_reg),
        .en(en),
        .rd_en(rd_en),
        .rd_addr(s1_reg.addr),
        .wr_en(wr_en),
        .wr_addr(s2_reg.addr),
        .wr_lane_n(s2_reg.lane_sel_n),
        .wr_data(data_in),
        .rd_data(data_out)
    );

    // output enable gates the pipelined drive with no clock in the path
    assign data_oe = drive_reg && !output_enable_n;

    // checks

    sequence s_read_load;
        en && load && selected && write_enable_n;
    endsequence

    sequence s_write_load;
        en && load && selected && !write_enable_n;
    endsequence

    sequence s_deselect;
        en && load && !selected;
    endsequence

    property p_read_drives;
        @(posedge clk_sys) disable iff (!rst_n_reg)
        s_read_load ##1 en |=> drive_reg;
    endproperty
    a_read_drives: assert property (p_read_drives)
        else $error("read did not drive data two cycles later");

    property p_write_hiz;
        @(posedge clk_sys) disable iff (!rst_n_reg)
        s_write_load ##1 en |=> !drive_reg;
    endproperty
    a_write_hiz: assert property (p_write_hiz)
        else $error("outputs driven during write data cycle");

    property p_deselect_hiz;
        @(posedge clk_sys) disable iff (!rst_n_reg)
        s_deselect ##1 en |=> !drive_reg;
    endproperty
    a_deselect_hiz: assert property (p_deselect_hiz)
        else $error("outputs driven two cycles after deselect");

    property p_deselect_stops;
        @(posedge clk_sys) disable iff (!rst_n_reg)
        s_deselect |=> !burst_reg.active && !s1_reg.valid;
    endproperty
    a_deselect_stops: assert property (p_deselect_stops)
        else $error("burst survived a deselect");

    property p_pending_finish;
        @(posedge clk_sys) disable iff (!rst_n_reg)
        (en && s1_reg.valid && s1_reg.write) |=> s2_reg.valid && s2_reg.write;
    endproperty
    a_pending_finish: assert property (p_pending_finish)
        else $error("pending write dropped from pipeline");

    property p_stall_holds;
        @(posedge clk_sys) disable iff (!rst_n_reg)
        !en |=> $stable(s1_reg) && $stable(s2_reg) && $stable(burst_reg)
            && $stable(drive_reg) && $stable(data_out);
    endproperty
    a_stall_holds: assert property (p_stall_holds)
        else $error("state changed while clock enable was high");

    property p_load_addr;
        @(posedge clk_sys) disable iff (!rst_n_reg)
        (en && load && selected) |=> s1_reg.addr == $past(addr)
            && burst_reg.count == burst_sram_pkg::BURST_FIRST;
    endproperty
    a_load_addr: assert property (p_load_addr)
        else $error("load cycle did not take the external address");

    property p_advance_count;
        @(posedge clk_sys) disable iff (!rst_n_reg)
        (en && advance_ok) |=> burst_reg.count ==
            $past(burst_reg.count) + burst_sram_pkg::BURST_STEP;
    endproperty
    a_advance_count: assert property (p_advance_count)
        else $error("burst counter did not step");

    property p_interleaved;
        @(posedge clk_sys) disable iff (!rst_n_reg)
        (en && advance_ok && mode_reg) |=>
            s1_reg.addr[burst_sram_pkg::BURST_W-1:0] ==
            (burst_reg.base[burst_sram_pkg::BURST_W-1:0] ^ burst_reg.count);
    endproperty
    a_interleaved: assert property (p_interleaved)
        else $error("interleaved burst address wrong");

    property p_linear;
        @(posedge clk_sys) disable iff (!rst_n_reg)
        (en && advance_ok && !mode_reg) |=>
            s1_reg.addr[burst_sram_pkg::BURST_W-1:0] ==
            burst_reg.base[burst_sram_pkg::BURST_W-1:0] + burst_reg.count;
    endproperty
    a_linear: assert property (p_linear)
        else $error("linear burst address wrong");

    property p_oe_forces_off;
        @(posedge clk_sys) disable iff (!rst_n_reg)
        output_enable_n |-> !data_oe;
    endproperty
    a_oe_forces_off: assert property (p_oe_forces_off)
        else $error("outputs driven with output enable high");

    property p_rw_kind;
        @(posedge clk_sys) disable iff (!rst_n_reg)
        (en && load && selected) |=> s1_reg.write == !$past(write_enable_n)
            && s1_reg.lane_sel_n == $past(lane_sel_n);
    endproperty
    a_rw_kind: assert property (p_rw_kind)
        else $error("access kind or lane selects not captured");

    property p_write_data_cycle;
        @(posedge clk_sys) disable iff (!rst_n_reg)
        s_write_load ##1 en |=> wr_en && s2_reg.addr == $past(addr, 2);
    endproperty
    a_write_data_cycle: assert property (p_write_data_cycle)
        else $error("write data not taken two cycles after address");

    property p_back_to_back;
        @(posedge clk_sys) disable iff (!rst_n_reg)
        s_write_load ##1 s_read_load |=> wr_en && rd_en;
    endproperty
    a_back_to_back: assert property (p_back_to_back)
        else $error("write then read did not overlap in the pipeline");

    property p_deselect_pending;
        @(posedge clk_sys) disable iff (!rst_n_reg)
        (en && load && !selected && s1_reg.valid && !s1_reg.write)
            |=> drive_reg;
    endproperty
    a_deselect_pending: assert property (p_deselect_pending)
        else $error("pending read dropped by a deselect");

    property p_burst_word;
        @(posedge clk_sys) disable iff (!rst_n_reg)
        (en && advance_ok) |=> s1_reg.valid
            && s1_reg.write == $past(burst_reg.write)
            && s1_reg.lane_sel_n == $past(lane_sel_n);
    endproperty
    a_burst_word: assert property (p_burst_word)
        else $error("burst word kind or lane selects wrong");

    property p_stall_write;
        @(posedge clk_sys) disable iff (!rst_n_reg)
        (!en && wr_en) |=> wr_en;
    endproperty
    a_stall_write: assert property (p_stall_write)
        else $error("pending write lost during a stall");

endmodule : pipelined_sync_burst_sram

// ---- bench/sram_ctrl_partner.sv ----
// controller-side partner model driving write data in its data cycle
`timescale 1ns/10ps
module sram_ctrl_partner (
    input wire logic clk_sys,
    input wire logic want,
    input wire logic [burst_sram_pkg::DATA_W-1:0] word,
    output logic [burst_sram_pkg::DATA_W-1:0] data_in
);
    logic [burst_sram_pkg::DATA_W-1:0] last_reg = '0;

    // a released bus shows the inverse of its value one cycle earlier, so it changes every cycle
    assign data_in = want ? word : ~last_reg;

    always @(posedge clk_sys) begin
        last_reg <= data_in;
    end
endmodule : sram_ctrl_partner

// ---- bench/pipelined_sync_burst_sram_tb.sv ----
// self-checking bench for the pipelined burst sram
`timescale 1ns/10ps
module pipelined_sync_burst_sram_tb;
    localparam int AW = burst_sram_pkg::ADDR_W;
    localparam int DW = burst_sram_pkg::DATA_W;
    localparam int LIMIT = 2000;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [AW-1:0] addr = '0;
    logic cs1_n = 1'b1;
    logic cs2 = 1'b0;
    logic cs3_n = 1'b1;
    logic adv = 1'b0;
    logic cen_n = 1'b0;
    logic we_n = 1'b1;
    logic [3:0] lane_n = 4'hF;
    logic mode = 1'b0;
    logic oe_n = 1'b0;
    logic want = 1'b0;
    logic [DW-1:0] word = '0;
    logic [DW-1:0] data_in;
    logic [DW-1:0] data_out;
    logic data_oe;
    integer seed = 32'hA722F6E7;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [DW-1:0] mem [int];
    burst_sram_pkg::access_t nx = '0;
    burst_sram_pkg::access_t d1 = '0;
    burst_sram_pkg::access_t ph = '0;
    burst_sram_pkg::burst_t bst = '0;
    logic drv = 1'b0;
    logic [AW-1:0] blk = 19'h5A5C0;

    pipelined_sync_burst_sram dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .addr(addr),
        .chip_select_1_n(cs1_n), .chip_select_2(cs2),
        .chip_select_3_n(cs3_n), .advance_or_load(adv),
        .clock_enable_n(cen_n), .write_enable_n(we_n),
        .byte_write_sel_lane0_n(lane_n[0]),
        .byte_write_sel_lane1_n(lane_n[1]),
        .byte_write_sel_lane2_n(lane_n[2]),
        .byte_write_sel_lane3_n(lane_n[3]),
        .burst_order_interleaved(mode), .output_enable_n(oe_n),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe)
    );

    sram_ctrl_partner ctrl (
        .clk_sys(clk_sys), .want(want), .word(word), .data_in(data_in)
    );

    always #2.5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            $display("Error at %0t: run did not finish", $time);
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask : chk

    // kind: 0 read, 1-2 write, 3 deselect, 4-6 advance, 7 stall, -1 random
    task automatic step(input int kind, input logic [AW-1:0] a);
        int r;
        logic e;
        logic [DW-1:0] m;
        logic [1:0] lo;
        @(posedge clk_sys);
        #1;
        e = !cen_n;
        if (e) begin
            ph = d1;
            d1 = nx;
            want = ph.valid & ph.write;
            drv = ph.valid & ~ph.write;
            if (want) begin
                word = DW'({$random(seed), $random(seed)});
                m = mem[int'(ph.addr)];
                for (int i = 0; i < 4; i++)
                    if (!ph.lane_sel_n[i]) m[i*9 +: 9] = word[i*9 +: 9];
                mem[int'(ph.addr)] = m;
            end
        end
        r = (kind < 0) ? ($random(seed) & 7) : kind;
        oe_n = (kind < 0) && (($random(seed) & 7) == 0);
        cen_n = (r == 7);
        we_n = !(r == 1 || r == 2);
        adv = (r >= 4 && r <= 6 && bst.active);
        lane_n = (kind < 0) ? 4'($random(seed)) : 4'h0;
        addr = (kind < 0) ? blk + AW'($random(seed) & 15) : a;
        if (r != 3) {cs1_n, cs2, cs3_n} = 3'h2;
        else if (cycles % 3 == 0) {cs1_n, cs2, cs3_n} = 3'h6;
        else if (cycles % 3 == 1) {cs1_n, cs2, cs3_n} = 3'h0;
        else {cs1_n, cs2, cs3_n} = 3'h3;
        if (!cen_n) begin
            nx = '0;
            if (r == 3) begin
                bst.active = 1'b0;
            end else if (!adv) begin
                bst = '{1'b1, !we_n, addr, 2'h0};
                nx = '{1'b1, !we_n, addr, lane_n};
            end else begin
                bst.count = bst.count + 2'h1;
                lo = mode ? bst.base[1:0] ^ bst.count
                          : bst.base[1:0] + bst.count;
                nx = '{1'b1, bst.write, {bst.base[AW-1:2], lo}, lane_n};
            end
        end
        #1;
        if (e && drv) chk(data_out === mem[int'(ph.addr)], "read data");
        chk(data_oe === (drv & ~oe_n), "output drive");
    endtask : step

    initial begin
        repeat (4) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        repeat (3) step(3, blk);
        for (int i = 0; i < 16; i++) step(1, blk + AW'(i));
        repeat (2) step(3, blk);
        $display("test fill done");
        for (int m = 0; m < 2; m++) begin
            mode = m[0];
            repeat (4) step(3, blk);
            repeat (400) step(-1, blk);
            repeat (2) step(3, blk);
            $display("test random mode %0d done", m);
        end
        close_out();
    end
endmodule : pipelined_sync_burst_sram_tb
